// ### rtl/dspdc_pkg.sv
package dspdc_pkg;

   // ------------------------------------------------------------
   // Serial word layout
   // ------------------------------------------------------------
   localparam int WORD_BITS = 23;
   localparam int POS_TARGET = 0;
   localparam int POS_REF_RATIO = 1;
   localparam int POS_MON_SEL = 2;
   localparam int POS_FILLER = 3;
   localparam int POS_POLARITY = 4;
   localparam int POS_SWALLOW = 5;
   localparam int SWALLOW_BITS = 7;
   localparam int POS_MAIN = 12;
   localparam int MAIN_BITS = 11;

   // ------------------------------------------------------------
   // Divider figures
   // ------------------------------------------------------------
   localparam int PRESCALE_BASE = 64;
   localparam int REF_DIV_HI = 512;
   localparam int REF_DIV_LO = 1024;
   localparam int REF_BITS = 10;

   // ------------------------------------------------------------
   // Lock detector timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOCK_WINDOW_NS = 625;
   localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_GOOD_COUNT = 3;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_TX_CFG = 5'h08;
   localparam logic [4:0] REG_RX_CFG = 5'h0C;
   localparam logic [4:0] REG_SHIFT = 5'h10;
   localparam logic CTRL_LINK_EN_RST = 1'b1;

   typedef struct packed {
      logic polarity;
      logic [SWALLOW_BITS-1:0] swallow;
      logic [MAIN_BITS-1:0] main;
   } dspdc_chan_cfg_t;

   localparam dspdc_chan_cfg_t CHAN_CFG_RST = '0;

   typedef struct packed {
      logic mon_sel;
      logic ref_ratio;
      logic rx_good;
      logic tx_good;
      logic rx_lock;
      logic tx_lock;
   } dspdc_status_t;

   typedef struct packed {
      logic sdata;
      logic sclk;
      logic strobe;
      logic tx_pre;
      logic rx_pre;
      logic xtal;
      logic tx_sup;
      logic rx_sup;
   } dspdc_pins_t;

endpackage

// ### rtl/dspdc_chan.sv
`timescale 1ns/1ps
`default_nettype none

module dspdc_chan (
   input wire logic ref_clk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic pre_rise, // Prescaler input edge
   input wire logic ref_pulse, // Divided reference event
   input wire dspdc_pkg::dspdc_chan_cfg_t cfg, // Latched channel setting
   output logic div_sig, // Divided signal level
   output logic div_pulse, // Divided signal event
   output logic lock, // Lock indicator
   output logic pump_out, // Pump drive level
   output logic pump_oe // Pump drive enable
);

   localparam int EW = $clog2(dspdc_pkg::LOCK_WINDOW_CYC + 1);
   localparam logic [6:0] PRE_LAST_LO = 7'(dspdc_pkg::PRESCALE_BASE - 1);
   localparam logic [6:0] PRE_LAST_HI = 7'(dspdc_pkg::PRESCALE_BASE);
   localparam logic [EW-1:0] ERR_WIDE = EW'(dspdc_pkg::LOCK_WINDOW_CYC - 1);
   localparam logic [EW-1:0] ERR_MAX = EW'(dspdc_pkg::LOCK_WINDOW_CYC);
   localparam logic [1:0] GOOD_LAST = 2'(dspdc_pkg::LOCK_GOOD_COUNT - 1);

   logic [6:0] pre_cnt;
   logic [6:0] a_left;
   logic [10:0] m_cnt;
   logic up_q;
   logic dn_q;
   logic [EW-1:0] err_cnt;
   logic [1:0] good_cnt;

   // ------------------------------------------------------------
   // Pulse-swallow divider
   // ------------------------------------------------------------
   wire swallow_on = a_left != 7'h00;
   wire [6:0] pre_last = swallow_on ? PRE_LAST_HI : PRE_LAST_LO; // R7
   wire pre_wrap = pre_rise & (pre_cnt == pre_last);
   wire [10:0] main_last = cfg.main - 11'h001;
   wire main_wrap = pre_wrap & (m_cnt >= main_last); // R6
   wire [6:0] next_pre_cnt = pre_wrap ? 7'h00 : (pre_rise ? pre_cnt + 7'h01 : pre_cnt);
   wire [6:0] next_a_left = main_wrap ? cfg.swallow : // R5 R21
      ((pre_wrap & swallow_on) ? a_left - 7'h01 : a_left); // R8
   wire [10:0] next_m_cnt = main_wrap ? 11'h000 : (pre_wrap ? m_cnt + 11'h001 : m_cnt);

   // ------------------------------------------------------------
   // Phase detector and lock window
   // ------------------------------------------------------------
   wire ref_side = up_q | ref_pulse;
   wire div_side = dn_q | main_wrap;
   wire compare_done = ref_side & div_side;
   wire next_up = ref_side & ~div_side;
   wire next_dn = div_side & ~ref_side;
   wire err_wide = (up_q | dn_q) & (err_cnt >= ERR_WIDE);
   wire narrow_cmp = compare_done & ~err_wide;
   wire [EW-1:0] next_err = compare_done ? '0 :
      (((up_q | dn_q) & (err_cnt != ERR_MAX)) ? err_cnt + EW'(1) : err_cnt);
   wire [1:0] next_good = err_wide ? 2'h0 :
      ((narrow_cmp & (good_cnt != GOOD_LAST)) ? good_cnt + 2'h1 : good_cnt);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= 7'h00;
         a_left <= 7'h00;
         m_cnt <= 11'h000;
         div_sig <= 1'b0;
         div_pulse <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         a_left <= next_a_left;
         m_cnt <= next_m_cnt;
         div_sig <= next_m_cnt < {1'b0, cfg.main[10:1]};
         div_pulse <= main_wrap;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
         err_cnt <= '0;
         good_cnt <= 2'h0;
         lock <= 1'b0;
         pump_out <= 1'b0;
         pump_oe <= 1'b0;
      end else begin
         up_q <= next_up;
         dn_q <= next_dn;
         err_cnt <= next_err;
         good_cnt <= next_good;
         if (err_wide) begin
            lock <= 1'b0; // R12 R20
         end else if (narrow_cmp && good_cnt == GOOD_LAST) begin
            lock <= 1'b1; // R12 R20
         end
         pump_oe <= next_up | next_dn; // R19
         pump_out <= next_up ? cfg.polarity : ~cfg.polarity; // R13 R19
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_wide_error;
      (up_q | dn_q) && err_cnt >= ERR_WIDE;
   endsequence

   a_prescale_modulus: assert property (pre_wrap |-> pre_cnt == (swallow_on ? 7'd64 : 7'd63)) // R7
      else $error("prescaler wrapped at wrong modulus");
   a_swallow_reload: assert property (main_wrap |=> a_left == $past(cfg.swallow)) // R8
      else $error("swallow count not reloaded at main wrap");
   a_lock_drop: assert property (s_wide_error |=> !lock ##1 !lock) // R20
      else $error("lock not dropped after wide error");
   a_pump_polarity: assert property (pump_oe |-> // R19
      pump_out == (up_q ? $past(cfg.polarity) : ~$past(cfg.polarity)))
      else $error("pump drive level wrong for polarity");

endmodule // dspdc_chan

`default_nettype wire

// ### rtl/dspdc_top.sv
// Functional notes
// (R1) Serial clock rise shifts one bit in
// (R2) Strobe high copies word to target latch
// (R3) Host drives data, clock, strobe only
// (R4) Loading one channel keeps other unchanged
// (R5) Swallow counter accepts 0 to 127
// (R6) Main counter spans 16 to 2047
// (R7) Prescaler divides by 64 or 65
// (R8) Total division is 64 main plus swallow
// (R9) Reference divides crystal by 512 or 1024
// (R10) Monitor output shows divided reference
// (R11) Monitor select picks transmit or reception
// (R12) Lock flag high locked, low unlocked
// (R13) Polarity bit inverts detector and pump
// (R14) Switch follows pump only while loading
// (R15) Transmit supply loss clears transmit latch
// (R16) Reception supply loss clears latch, reference
// (R17) Word order: target first, main last
// (R18) Ratio bit high 512, low 1024
// (R19) Pump drive levels follow phase and polarity
// (R20) Lock drops on wide error, three narrow
// (R21) Latches hold; counters use latched values
// (R22) Host strobes only after 23 bits
// (R23) Filler bit low, ignored by device
`timescale 1ns/1ps
`default_nettype none

module dspdc_top (
   input wire logic ref_clk, // 40 MHz clock
   input wire logic nrst, // Async reset, active low
   input wire logic [4:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic serial_data, // Serial data pin
   input wire logic serial_clock, // Serial clock pin
   input wire logic latch_strobe, // Latch strobe pin
   input wire logic crystal_input, // Crystal clock pin
   input wire logic tx_prescaler_input, // Transmit VCO pin
   input wire logic rx_prescaler_input, // Reception VCO pin
   input wire logic tx_supply_domain, // Transmit supply good
   input wire logic rx_supply_domain, // Reception supply good
   output logic reference_divided_monitor, // Divided reference
   output logic divider_monitor_output, // Selected divider
   output logic tx_divided_signal, // Transmit divider
   output logic rx_divided_signal, // Reception divider
   output logic tx_lock_flag, // Transmit lock
   output logic rx_lock_flag, // Reception lock
   output logic tx_pump_output, // Transmit pump level
   output logic tx_pump_oe, // Transmit pump enable
   output logic rx_pump_output, // Reception pump level
   output logic rx_pump_oe, // Reception pump enable
   output logic tx_switch_output, // Transmit switch level
   output logic tx_switch_oe, // Transmit switch enable
   output logic rx_switch_output, // Reception switch level
   output logic rx_switch_oe // Reception switch enable
);

   localparam int NPIN = $bits(dspdc_pkg::dspdc_pins_t);
   localparam int WB = dspdc_pkg::WORD_BITS;
   localparam logic [9:0] REF_LAST_HI = 10'(dspdc_pkg::REF_DIV_HI - 1);
   localparam logic [9:0] REF_LAST_LO = 10'(dspdc_pkg::REF_DIV_LO - 1);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync_a;
   logic [NPIN-1:0] sync_b;
   logic [NPIN-1:0] sync_c;

   assign pin_raw = {serial_data, serial_clock, latch_strobe, tx_prescaler_input,
                     rx_prescaler_input, crystal_input, tx_supply_domain, rx_supply_domain};

   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            sync_a[i] <= 1'b0;
            sync_b[i] <= 1'b0;
            sync_c[i] <= 1'b0;
         end else begin
            sync_a[i] <= pin_raw[i];
            sync_b[i] <= sync_a[i];
            sync_c[i] <= sync_b[i];
         end
      end
   end

   dspdc_pkg::dspdc_pins_t pins_s;
   dspdc_pkg::dspdc_pins_t pins_d;
   assign pins_s = dspdc_pkg::dspdc_pins_t'(sync_b);
   assign pins_d = dspdc_pkg::dspdc_pins_t'(sync_c);

   wire sclk_rise = pins_s.sclk & ~pins_d.sclk;
   wire tx_pre_rise = pins_s.tx_pre & ~pins_d.tx_pre;
   wire rx_pre_rise = pins_s.rx_pre & ~pins_d.rx_pre;
   wire xtal_rise = pins_s.xtal & ~pins_d.xtal;
   wire tx_good = pins_s.tx_sup;
   wire rx_good = pins_s.rx_sup;

   // ------------------------------------------------------------
   // Shift register and latches
   // ------------------------------------------------------------
   logic link_en;
   logic [WB-1:0] shift_reg;
   dspdc_pkg::dspdc_chan_cfg_t tx_cfg;
   dspdc_pkg::dspdc_chan_cfg_t rx_cfg;
   logic ref_ratio;
   logic mon_sel;

   wire shift_go = sclk_rise & link_en;
   wire [WB-1:0] next_shift = {pins_s.sdata, shift_reg[WB-1:1]}; // R1 R17
   wire target = shift_reg[dspdc_pkg::POS_TARGET];
   wire load_go = pins_s.strobe & link_en; // R2
   wire load_tx = load_go & target & tx_good; // R2 R4
   wire load_rx = load_go & ~target & rx_good; // R2 R4
   dspdc_pkg::dspdc_chan_cfg_t word_cfg;
   assign word_cfg.polarity = shift_reg[dspdc_pkg::POS_POLARITY]; // R23
   assign word_cfg.swallow = shift_reg[dspdc_pkg::POS_SWALLOW +: dspdc_pkg::SWALLOW_BITS];
   assign word_cfg.main = shift_reg[dspdc_pkg::POS_MAIN +: dspdc_pkg::MAIN_BITS];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         shift_reg <= '0;
      end else if (shift_go) begin
         shift_reg <= next_shift; // R1
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_cfg <= dspdc_pkg::CHAN_CFG_RST;
      end else if (!tx_good) begin
         tx_cfg <= dspdc_pkg::CHAN_CFG_RST; // R15
      end else if (load_tx) begin
         tx_cfg <= word_cfg; // R2 R21
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_cfg <= dspdc_pkg::CHAN_CFG_RST;
         ref_ratio <= 1'b0;
         mon_sel <= 1'b0;
      end else if (!rx_good) begin
         rx_cfg <= dspdc_pkg::CHAN_CFG_RST; // R16
         ref_ratio <= 1'b0; // R16
         mon_sel <= 1'b0;
      end else if (load_tx || load_rx) begin
         if (load_rx) begin
            rx_cfg <= word_cfg; // R2 R21
         end
         ref_ratio <= shift_reg[dspdc_pkg::POS_REF_RATIO]; // R18
         mon_sel <= shift_reg[dspdc_pkg::POS_MON_SEL]; // R11
      end
   end

   // ------------------------------------------------------------
   // Reference divider
   // ------------------------------------------------------------
   logic [9:0] ref_cnt;
   wire [9:0] ref_last = ref_ratio ? REF_LAST_HI : REF_LAST_LO; // R9 R18
   wire ref_wrap = xtal_rise & (ref_cnt >= ref_last); // R9
   wire [9:0] next_ref_cnt = ref_wrap ? 10'h000 : (xtal_rise ? ref_cnt + 10'h001 : ref_cnt);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ref_cnt <= 10'h000;
         reference_divided_monitor <= 1'b0;
      end else begin
         ref_cnt <= next_ref_cnt;
         reference_divided_monitor <= next_ref_cnt < {1'b0, ref_last[9:1]}; // R10
      end
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   dspdc_chan u_tx (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pre_rise(tx_pre_rise),
      .ref_pulse(ref_wrap),
      .cfg(tx_cfg),
      .div_sig(tx_divided_signal),
      .div_pulse(),
      .lock(tx_lock_flag),
      .pump_out(tx_pump_output),
      .pump_oe(tx_pump_oe)
   );

   dspdc_chan u_rx (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pre_rise(rx_pre_rise),
      .ref_pulse(ref_wrap),
      .cfg(rx_cfg),
      .div_sig(rx_divided_signal),
      .div_pulse(),
      .lock(rx_lock_flag),
      .pump_out(rx_pump_output),
      .pump_oe(rx_pump_oe)
   );

   // ------------------------------------------------------------
   // Monitor and analog switches
   // ------------------------------------------------------------
   wire tx_sw_on = pins_s.strobe & target; // R14
   wire rx_sw_on = pins_s.strobe & ~target; // R14

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         divider_monitor_output <= 1'b0;
         tx_switch_output <= 1'b0;
         tx_switch_oe <= 1'b0;
         rx_switch_output <= 1'b0;
         rx_switch_oe <= 1'b0;
      end else begin
         divider_monitor_output <= mon_sel ? tx_divided_signal : rx_divided_signal; // R11
         tx_switch_output <= tx_pump_output;
         tx_switch_oe <= tx_sw_on & tx_pump_oe; // R14
         rx_switch_output <= rx_pump_output;
         rx_switch_oe <= rx_sw_on & rx_pump_oe; // R14
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   dspdc_pkg::dspdc_status_t status;
   assign status = '{mon_sel: mon_sel, ref_ratio: ref_ratio, rx_good: rx_good,
                     tx_good: tx_good, rx_lock: rx_lock_flag, tx_lock: tx_lock_flag};

   wire [2:0] reg_idx = avs_address[4:2];
   wire sel_ctrl = reg_idx == dspdc_pkg::REG_CTRL[4:2];
   wire sel_status = reg_idx == dspdc_pkg::REG_STATUS[4:2];
   wire sel_tx = reg_idx == dspdc_pkg::REG_TX_CFG[4:2];
   wire sel_rx = reg_idx == dspdc_pkg::REG_RX_CFG[4:2];
   wire sel_shift = reg_idx == dspdc_pkg::REG_SHIFT[4:2];
   wire bus_req = avs_read | avs_write;
   wire wr_take = avs_write & ~avs_waitrequest;
   wire [31:0] rd_mux = sel_ctrl ? 32'(link_en) :
                        sel_status ? 32'(status) :
                        sel_tx ? 32'(tx_cfg) :
                        sel_rx ? 32'(rx_cfg) :
                        sel_shift ? 32'(shift_reg) : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         link_en <= dspdc_pkg::CTRL_LINK_EN_RST;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         avs_readdata <= (avs_read & avs_waitrequest) ? rd_mux : avs_readdata;
         if (wr_take && sel_ctrl) begin
            link_en <= avs_writedata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_tx_load;
      load_tx ##0 tx_good;
   endsequence

   sequence s_rx_steady;
      rx_good && !load_rx;
   endsequence

   a_shift_one_bit: assert property (shift_go |=> shift_reg == $past(next_shift)) // R1
      else $error("shift register did not take one bit");
   a_tx_latch_load: assert property (s_tx_load |=> tx_cfg == $past(word_cfg)) // R2
      else $error("transmit latch not loaded from word");
   a_rx_kept_tx_load: assert property (s_tx_load ##0 s_rx_steady |=> rx_cfg == $past(rx_cfg)) // R4
      else $error("reception latch changed on transmit load");
   a_latch_holds: assert property (!load_tx && tx_good |=> $stable(tx_cfg)) // R21
      else $error("transmit latch changed without strobe");
   a_tx_loss_clear: assert property (!tx_good |=> tx_cfg == dspdc_pkg::CHAN_CFG_RST) // R15
      else $error("transmit latch not cleared on supply loss");
   a_rx_loss_clear: assert property (!rx_good |=> rx_cfg == '0 && !ref_ratio) // R16
      else $error("reception latch not cleared on supply loss");
   a_ref_wrap_count: assert property (ref_wrap |-> ref_cnt == (ref_ratio ? 10'd511 : 10'd1023)) // R9
      else $error("reference divider wrapped at wrong count");
   a_monitor_select: assert property (nrst |=>
      divider_monitor_output == $past(mon_sel ? tx_divided_signal : rx_divided_signal)) // R11
      else $error("divider monitor shows wrong channel");
   a_switch_gate: assert property (tx_switch_oe |-> $past(pins_s.strobe && target && tx_pump_oe)) // R14
      else $error("transmit switch on outside load");

endmodule // dspdc_top

`default_nettype wire

// ### tb/dspdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dspdc_host_model (
   input wire logic ref_clk, // System clock
   output logic serial_data, // Serial data line
   output logic serial_clock, // Serial clock line
   output logic latch_strobe // Latch strobe line
);
   initial begin
      serial_data = 1'b0;
      serial_clock = 1'b0;
      latch_strobe = 1'b0;
   end

   // ----------
   // Word transfer, three lines only
   // ----------
   task automatic send_word(input logic [22:0] w, input int slow);
      for (int i = 0; i < 23; i++) begin
         serial_data <= w[i];
         repeat (2 + slow) @(posedge ref_clk);
         serial_clock <= 1'b1;
         repeat (2 + slow) @(posedge ref_clk);
         serial_clock <= 1'b0;
         repeat (2 + slow) @(posedge ref_clk);
      end
      latch_strobe <= 1'b1;
      repeat (4) @(posedge ref_clk);
      latch_strobe <= 1'b0;
      serial_data <= ~w[22];
      repeat (2) @(posedge ref_clk);
   endtask
endmodule // dspdc_host_model

`default_nettype wire

// ### tb/dspdc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dspdc_top_tb;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic serial_data;
   logic serial_clock;
   logic latch_strobe;
   logic crystal_input = 1'b0;
   logic tx_prescaler_input = 1'b0;
   logic rx_prescaler_input = 1'b0;
   logic tx_supply_domain = 1'b1;
   logic rx_supply_domain = 1'b1;
   logic reference_divided_monitor;
   logic divider_monitor_output;
   logic tx_divided_signal;
   logic tx_lock_flag;
   logic rx_lock_flag;
   logic tx_pump_oe;
   logic rx_pump_oe;
   logic tx_switch_oe;
   logic rx_switch_oe;
   logic [2:0] cyc = 3'h0;
   logic [31:0] rd;
   logic [22:0] w;
   int per;
   int fail_count = 0;
   int comparisons = 0;

   always #12.5 ref_clk = ~ref_clk;

   // Crystal and both VCO pins run slow, fixed ratios
   always @(posedge ref_clk) begin
      cyc <= cyc + 3'h1;
      crystal_input <= cyc[1];
      tx_prescaler_input <= cyc[1];
      rx_prescaler_input <= cyc[2];
   end

   dspdc_top uut (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .serial_data, .serial_clock, .latch_strobe,
      .crystal_input, .tx_prescaler_input, .rx_prescaler_input, .tx_supply_domain,
      .rx_supply_domain, .reference_divided_monitor, .divider_monitor_output,
      .tx_divided_signal, .rx_divided_signal(), .tx_lock_flag, .rx_lock_flag,
      .tx_pump_output(), .tx_pump_oe, .rx_pump_output(), .rx_pump_oe,
      .tx_switch_output(), .tx_switch_oe, .rx_switch_output(), .rx_switch_oe);

   dspdc_host_model host (.ref_clk, .serial_data, .serial_clock, .latch_strobe);

   // ----------
   // Bus access and checking
   // ----------
   task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_period(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
      bus_read(a, rd);
      check_reg(rd & m, exp);
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return tx_divided_signal;
         1: return reference_divided_monitor;
         default: return divider_monitor_output;
      endcase
   endfunction

   // Ref clock cycles between the first two rises, first rise starts the count
   task automatic measure(input int s, output int p);
      int t0;
      logic prev;
      logic cur;
      p = 0;
      t0 = -1;
      prev = 1'b1;
      for (int n = 0; n < 20000 && p == 0; n++) begin
         @(posedge ref_clk);
         cur = pick(s);
         if (prev === 1'b0 && cur === 1'b1) begin
            if (t0 < 0) t0 = n;
            else p = n - t0;
         end
         prev = cur;
      end
   endtask

   function automatic logic [22:0] mk(input logic t, input logic r, input logic m,
      input logic p, input logic [6:0] a, input logic [10:0] n);
      return {n, a, p, 1'b0, m, r, t};
   endfunction

   task automatic report_and_stop;
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ----------
   // Test sequence
   // ----------
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_TX_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(5'h14, 32'h0000_0000, 32'hFFFF_FFFF);
      check_reg({26'h000_0000, tx_lock_flag, rx_lock_flag, tx_pump_oe, rx_pump_oe,
         tx_switch_oe, rx_switch_oe}, 32'h0000_0000);
      w = mk(1'b1, 1'b1, 1'b1, 1'b1, 7'h03, 11'h010);
      host.send_word(w, 0);
      repeat (4) @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_SHIFT, {9'h000, w}, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_TX_CFG, {13'h0000, 1'b1, 7'h03, 11'h010}, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_RX_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_STATUS, 32'h0000_0030, 32'h0000_0030);
      bus_write(dspdc_pkg::REG_TX_CFG, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_TX_CFG, {13'h0000, 1'b1, 7'h03, 11'h010}, 32'hFFFF_FFFF);
      measure(0, per);
      check_period(per, 4 * (64 * 16 + 3));
      measure(2, per);
      check_period(per, 4 * (64 * 16 + 3));
      measure(1, per);
      check_period(per, 4 * 512);
      w = mk(1'b0, 1'b0, 1'b0, 1'b0, 7'h7F, 11'h7FF);
      host.send_word(w, 2);
      repeat (4) @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_RX_CFG, {13'h0000, 1'b0, 7'h7F, 11'h7FF}, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_TX_CFG, {13'h0000, 1'b1, 7'h03, 11'h010}, 32'hFFFF_FFFF);
      measure(1, per);
      check_period(per, 4 * 1024);
      w = mk(1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 11'h010);
      host.send_word(w, 0);
      repeat (4) @(posedge ref_clk);
      measure(2, per);
      check_period(per, 8 * 64 * 16);
      bus_write(dspdc_pkg::REG_CTRL, 32'h0000_0000);
      rd_chk(dspdc_pkg::REG_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
      host.send_word(mk(1'b1, 1'b0, 1'b0, 1'b0, 7'h11, 11'h022), 0);
      repeat (4) @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_SHIFT, {9'h000, w}, 32'hFFFF_FFFF);
      bus_write(dspdc_pkg::REG_CTRL, 32'h0000_0001);
      tx_supply_domain <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_TX_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_RX_CFG, {13'h0000, 1'b0, 7'h00, 11'h010}, 32'hFFFF_FFFF);
      rx_supply_domain <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_chk(dspdc_pkg::REG_RX_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(dspdc_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_0030);
      check_reg({30'h0000_0000, tx_switch_oe, rx_switch_oe}, 32'h0000_0000);
      report_and_stop;
   end

   initial begin
      repeat (95000) @(posedge ref_clk);
      fail_count++;
      report_and_stop;
   end
endmodule // dspdc_top_tb

`default_nettype wire
